// file: hdl/tcr_pkg.sv
package tcr_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_TSC = 6'h20;
  localparam logic [5:0] IDX_CNTH = 6'h21;
  localparam logic [5:0] IDX_CNTL = 6'h22;
  localparam logic [5:0] IDX_MODH = 6'h23;
  localparam logic [5:0] IDX_MODL = 6'h24;
  localparam logic [5:0] IDX_CSC0 = 6'h25;
  localparam logic [5:0] IDX_CVH0 = 6'h26;
  localparam logic [5:0] IDX_CVL0 = 6'h27;
  localparam logic [5:0] IDX_CSC1 = 6'h28;
  localparam logic [5:0] IDX_CVH1 = 6'h29;
  localparam logic [5:0] IDX_CVL1 = 6'h2A;

  // ---------------------------------------------------------------
  // Timer control/status field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned TSC_FLAG = 7;
  localparam int unsigned TSC_IRQEN = 6;
  localparam int unsigned TSC_HALT = 5;
  localparam int unsigned TSC_CLR = 4;
  localparam int unsigned TSC_PS_LSB = 0;
  localparam logic [7:0] TSC_RST = 8'h20;
  localparam logic [2:0] PS_NONE = 3'h7;
  localparam int unsigned PRE_W = 6;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'hFFFF;
  localparam logic [15:0] CV_RST = 16'h0000;
  localparam logic [7:0] CSC_RST = 8'h00;
  localparam int unsigned CH_N = 2;

  // Channel control/status byte, bit 7 first
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buf_mode;
    logic mode_a;
    logic els_b;
    logic els_a;
    logic tov;
    logic max;
  } tcr_ch_ctl_t;

  typedef enum logic [1:0] {
    MODE_PRESET,
    MODE_CAPTURE,
    MODE_COMPARE
  } tcr_mode_t;

endpackage

// file: hdl/tcr_timer.sv
// Functional notes
// [R1] Counter equal modulo sets overflow, restarts at zero
// [R2] Overflow flag clears by read-then-write zero
// [R3] Overflow irq needs enable and flag
// [R4] Halt bit freezes counter; set by reset
// [R5] Counter-clear zeroes counter and prescaler, reads zero
// [R6] Halt plus clear together: stopped at zero
// [R7] Prescale codes 0-6 divide by 1..64
// [R8] High-byte read latches low byte until read
// [R9] Modulo high write suppresses overflow until low
// [R10] Channel flag on capture edge or compare
// [R11] Channel flag clears by read-then-write zero
// [R12] Channel irq needs enable and flag
// [R13] Buffered bit on channel 0 disables channel 1
// [R14] Mode bit A: capture/compare or preset level
// [R15] Edge/level zero releases pin to port
// [R16] Capture edges: 01 rise, 10 fall, 11 both
// [R17] Compare action: 01 toggle, 10 low, 11 high
// [R18] Toggle-on-overflow in compare mode only
// [R19] Overflow action wins over coincident compare
// [R20] Full-duty force from the next period
// [R21] Software halts and clears before mode change
// [R22] Buffered mode switches to last-written pair
// [R23] Value high write/read inhibits compare/capture
// [R24] No overflow toggle with clear on compare gives zero duty
// [R25] Counter steps on prescaler tick when running
// [R26] Capture copies counter with flag set
`timescale 1ns/1ps
`default_nettype none

module tcr_timer
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CH_N-1:0] channel_pin_in,
  output logic [CH_N-1:0] channel_pin_out,
  output logic [CH_N-1:0] channel_pin_oe,
  output logic overflow_irq,
  output logic [CH_N-1:0] channel_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [5:0] idx;
  logic rd_fire, wr_fire, hit;
  logic [7:0] rdata;
  logic wr_tsc, wr_modh, wr_modl;
  logic rd_tsc, rd_cnth, rd_cntl;
  logic [CH_N-1:0] wr_csc, wr_cvh, wr_cvl, rd_csc, rd_cvh, rd_cvl;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic overflow_flag_q, overflow_irq_enable_q, counter_halt_q, ovf_arm_q;
  logic [2:0] prescale_select_q;
  logic [PRE_W-1:0] pre_q, pre_mask;
  logic [15:0] cnt_q, mod_q;
  logic arr_q, tick, ovf_evt, tof_set, mod_pend_q, ovf_irq_q;
  logic [7:0] lat_q;
  logic lat_v_q;
  logic act_q, last_q;
  tcr_ch_ctl_t ctl_q [CH_N];
  logic [15:0] cv_q [CH_N];
  logic [CH_N-1:0] cv_pend_q, cap_inh_q, out_q, oe_q, irq_q;

  // Word-aligned index and transfer phases
  assign idx = paddr[ADDR_W-1:2];
  assign rd_fire = pclk_en & psel & penable & ~pready_q & ~pwrite;
  assign wr_fire = pclk_en & psel & penable & pready_q & pwrite;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb begin
    hit = paddr[1:0] == 2'h0;
    rdata = 8'h00;
    wr_tsc = 1'b0;
    wr_modh = 1'b0;
    wr_modl = 1'b0;
    rd_tsc = 1'b0;
    rd_cnth = 1'b0;
    rd_cntl = 1'b0;
    wr_csc = '0;
    wr_cvh = '0;
    wr_cvl = '0;
    rd_csc = '0;
    rd_cvh = '0;
    rd_cvl = '0;
    if (!hit) begin
      rdata = 8'h00;
    end else if (idx == IDX_TSC) begin
      // Clear bit always reads zero
      rdata = {overflow_flag_q, overflow_irq_enable_q, counter_halt_q, 2'h0,
               prescale_select_q}; // R5
      wr_tsc = wr_fire;
      rd_tsc = rd_fire;
    end else if (idx == IDX_CNTH) begin
      rdata = cnt_q[15:8];
      rd_cnth = rd_fire;
    end else if (idx == IDX_CNTL) begin
      rdata = lat_v_q ? lat_q : cnt_q[7:0]; // R8
      rd_cntl = rd_fire;
    end else if (idx == IDX_MODH) begin
      rdata = mod_q[15:8];
      wr_modh = wr_fire;
    end else if (idx == IDX_MODL) begin
      rdata = mod_q[7:0];
      wr_modl = wr_fire;
    end else if (idx == IDX_CSC0) begin
      rdata = ctl_q[0];
      wr_csc[0] = wr_fire;
      rd_csc[0] = rd_fire;
    end else if (idx == IDX_CVH0) begin
      rdata = cv_q[0][15:8];
      wr_cvh[0] = wr_fire;
      rd_cvh[0] = rd_fire;
    end else if (idx == IDX_CVL0) begin
      rdata = cv_q[0][7:0];
      wr_cvl[0] = wr_fire;
      rd_cvl[0] = rd_fire;
    end else if (idx == IDX_CSC1) begin
      rdata = ctl_q[1];
      wr_csc[1] = wr_fire & ~ctl_q[0].buf_mode; // R13
      rd_csc[1] = rd_fire;
    end else if (idx == IDX_CVH1) begin
      rdata = cv_q[1][15:8];
      wr_cvh[1] = wr_fire;
      rd_cvh[1] = rd_fire;
    end else if (idx == IDX_CVL1) begin
      rdata = cv_q[1][7:0];
      wr_cvl[1] = wr_fire;
      rd_cvl[1] = rd_fire;
    end else begin
      hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, data and error from flops
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (pclk_en) begin
      pready_q <= psel & penable & ~pready_q;
      if (psel && penable && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
        pslverr_q <= ~hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  // Tick when the low prescaler bits selected are all ones
  assign pre_mask = ~({PRE_W{1'b1}} << prescale_select_q);
  assign tick = (prescale_select_q != PS_NONE) && ((pre_q & pre_mask) == pre_mask); // R7
  assign ovf_evt = arr_q && (cnt_q == mod_q); // R1
  assign tof_set = ovf_evt & ~mod_pend_q; // R9

  // Counter steps on the same edge that the selected prescaler bits wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      cnt_q <= CNT_RST;
      arr_q <= 1'b0;
    end else if (pclk_en) begin
      arr_q <= 1'b0;
      if (wr_tsc && pwdata[TSC_CLR]) begin
        pre_q <= '0; // R5 R6
        cnt_q <= CNT_RST; // R5 R6
      end else if (!counter_halt_q) begin // R4
        pre_q <= pre_q + 1'b1; // R25
        if (tick) begin
          cnt_q <= (cnt_q == mod_q) ? CNT_RST : cnt_q + 16'h0001; // R1 R25
          arr_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer control/status register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= TSC_RST[TSC_FLAG];
      overflow_irq_enable_q <= TSC_RST[TSC_IRQEN]; // R3
      counter_halt_q <= TSC_RST[TSC_HALT]; // R4
      prescale_select_q <= TSC_RST[TSC_PS_LSB +: 3]; // R7
      ovf_arm_q <= 1'b0;
    end else if (pclk_en) begin
      // New overflow wins over a clear
      if (tof_set) begin
        overflow_flag_q <= 1'b1; // R1
        ovf_arm_q <= 1'b0; // R2
      end else if (wr_tsc) begin
        if (ovf_arm_q && !pwdata[TSC_FLAG]) begin
          overflow_flag_q <= 1'b0; // R2
        end
        ovf_arm_q <= 1'b0;
      end else if (rd_tsc && overflow_flag_q) begin
        ovf_arm_q <= 1'b1; // R2
      end
      if (wr_tsc) begin
        overflow_irq_enable_q <= pwdata[TSC_IRQEN];
        counter_halt_q <= pwdata[TSC_HALT]; // R4 R6
        prescale_select_q <= pwdata[TSC_PS_LSB +: 3]; // R7
      end
    end
  end

  // Overflow request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_irq_q <= 1'b0;
    end else if (pclk_en) begin
      ovf_irq_q <= overflow_flag_q & overflow_irq_enable_q; // R3
    end
  end

  // ---------------------------------------------------------------
  // Coherent counter read and modulo
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= 8'h00;
      lat_v_q <= 1'b0;
    end else if (pclk_en) begin
      if (wr_tsc && pwdata[TSC_CLR]) begin
        lat_v_q <= 1'b0; // R8
      end else if (rd_cnth && !lat_v_q) begin
        lat_q <= cnt_q[7:0]; // R8
        lat_v_q <= 1'b1;
      end else if (rd_cntl) begin
        lat_v_q <= 1'b0; // R8
      end
    end
  end

  // Modulo bytes with high-first guard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_q <= MOD_RST; // R9
      mod_pend_q <= 1'b0;
    end else if (pclk_en) begin
      if (wr_modh) begin
        mod_q[15:8] <= pwdata[7:0];
        mod_pend_q <= 1'b1; // R9
      end else if (wr_modl) begin
        mod_q[7:0] <= pwdata[7:0];
        mod_pend_q <= 1'b0; // R9
      end
    end
  end

  // ---------------------------------------------------------------
  // Buffered pair selection
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      last_q <= 1'b0;
    end else if (pclk_en) begin
      if (wr_cvl[1] || wr_cvh[1]) begin
        last_q <= 1'b1;
      end else if (wr_cvl[0] || wr_cvh[0]) begin
        last_q <= 1'b0;
      end
      if (!ctl_q[0].buf_mode) begin
        act_q <= 1'b0;
      end else if (ovf_evt) begin
        act_q <= last_q; // R22
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    logic s1_q, s2_q, s3_q, stab_q;
    logic edge_ok, rise, fall, cap, match, cmp_inh, act_lvl, force_now;
    logic [15:0] cmp_val;
    tcr_mode_t mode;

    // Effective mode of this channel
    always_comb begin
      if ((i == 1 && ctl_q[0].buf_mode) || {ctl_q[i].els_b, ctl_q[i].els_a} == 2'h0) begin
        mode = MODE_PRESET; // R13 R15
      end else if (ctl_q[i].buf_mode || ctl_q[i].mode_a) begin
        mode = MODE_COMPARE; // R14
      end else begin
        mode = MODE_CAPTURE; // R14
      end
    end

    // Compare source follows the active pair in buffered mode
    assign cmp_val = (i == 0 && ctl_q[0].buf_mode) ? cv_q[act_q] : cv_q[i]; // R22
    assign cmp_inh = (i == 0 && ctl_q[0].buf_mode) ? cv_pend_q[act_q] : cv_pend_q[i];
    assign match = (mode == MODE_COMPARE) && arr_q && (cnt_q == cmp_val) && !cmp_inh; // R10 R23

    // Edge detect on the filtered pin level
    assign edge_ok = (s2_q == s3_q) && (s3_q != stab_q);
    assign rise = edge_ok & s3_q;
    assign fall = edge_ok & ~s3_q;
    assign cap = (mode == MODE_CAPTURE) && !cap_inh_q[i] &&
                 ((ctl_q[i].els_a && rise) || (ctl_q[i].els_b && fall)); // R16 R23

    // Active level of a pulse: complement of the compare action
    assign act_lvl = ctl_q[i].els_a ? 1'b0 : 1'b1;
    assign force_now = ctl_q[i].max & ctl_q[i].tov;

    // Three-flop pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        stab_q <= 1'b0;
      end else if (pclk_en) begin
        s1_q <= channel_pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          stab_q <= s3_q;
        end
      end
    end

    // Control/status byte and flag handshake
    logic arm_q, max_eff_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_q[i] <= CSC_RST; // R11 R12 R13 R15 R18
        arm_q <= 1'b0;
      end else if (pclk_en) begin
        // New event wins over a clear
        if (match || cap) begin
          ctl_q[i].flag <= 1'b1; // R10
          arm_q <= 1'b0; // R11
        end else if (wr_csc[i]) begin
          if (arm_q && !pwdata[7]) begin
            ctl_q[i].flag <= 1'b0; // R11
          end
          arm_q <= 1'b0;
        end else if (rd_csc[i] && ctl_q[i].flag) begin
          arm_q <= 1'b1; // R11
        end
        if (wr_csc[i]) begin
          ctl_q[i].irq_en <= pwdata[6];
          ctl_q[i].buf_mode <= (i == 0) ? pwdata[5] : 1'b0; // R13
          ctl_q[i].mode_a <= pwdata[4];
          ctl_q[i].els_b <= pwdata[3];
          ctl_q[i].els_a <= pwdata[2];
          ctl_q[i].tov <= pwdata[1];
          ctl_q[i].max <= pwdata[0];
        end
      end
    end

    // Channel value bytes, capture copy and inhibits
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cv_q[i] <= CV_RST;
        cv_pend_q[i] <= 1'b0;
        cap_inh_q[i] <= 1'b0;
      end else if (pclk_en) begin
        if (wr_cvh[i]) begin
          cv_q[i][15:8] <= pwdata[7:0];
          cv_pend_q[i] <= 1'b1; // R23
        end else if (wr_cvl[i]) begin
          cv_q[i][7:0] <= pwdata[7:0];
          cv_pend_q[i] <= 1'b0; // R23
        end else if (cap) begin
          cv_q[i] <= cnt_q; // R26
        end
        if (rd_cvh[i] && mode == MODE_CAPTURE) begin
          cap_inh_q[i] <= 1'b1; // R23
        end else if (rd_cvl[i]) begin
          cap_inh_q[i] <= 1'b0; // R23
        end
      end
    end

    // Pin level, drive enable and request
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[i] <= 1'b1;
        oe_q[i] <= 1'b0;
        irq_q[i] <= 1'b0;
        max_eff_q <= 1'b0;
      end else if (pclk_en) begin
        irq_q[i] <= ctl_q[i].flag & ctl_q[i].irq_en; // R12
        oe_q[i] <= mode == MODE_COMPARE; // R15
        if (ovf_evt) begin
          max_eff_q <= force_now; // R20
        end
        case (mode)
          MODE_PRESET: begin
            out_q[i] <= ~ctl_q[i].mode_a; // R14
          end
          MODE_COMPARE: begin
            if (ovf_evt && ctl_q[i].tov) begin
              out_q[i] <= force_now ? act_lvl : ~out_q[i]; // R18 R19 R20
            end else if (match && !max_eff_q) begin
              // Without overflow toggles, clear on compare settles low: zero duty
              case ({ctl_q[i].els_b, ctl_q[i].els_a}) // R24
                2'h1: out_q[i] <= ~out_q[i]; // R17
                2'h2: out_q[i] <= 1'b0; // R17
                default: out_q[i] <= 1'b1; // R17
              endcase
            end
          end
          default: begin
            out_q[i] <= out_q[i]; // R18
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_irq = ovf_irq_q;
  assign channel_irq = irq_q;
  assign channel_pin_out = out_q;
  assign channel_pin_oe = oe_q;

endmodule

`default_nettype wire

// file: test/tcr_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tcr_monitor
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CH_N-1:0] channel_pin_oe,
  input wire logic overflow_irq,
  input wire logic [CH_N-1:0] channel_irq
);
  // ----------------
  // Bus and outputs
  // ----------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Misaligned or outside the register map
  logic bad_addr;
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr[7:2] < IDX_TSC)
    || (paddr[7:2] > IDX_CVL1);

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h00000000)
    else $error("read data driven on write");
  a_err_decode: assert property (pready |-> pslverr == bad_addr)
    else $error("slave error does not match decode");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without pready");
  a_oe_by_write: assert property ($changed(channel_pin_oe) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("pin enable changed without a write");
  a_irq_drop_write: assert property (
    (|($past(channel_irq) & ~channel_irq)) || $fell(overflow_irq) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2)
    || $past(pready && pwrite, 3))
    else $error("interrupt dropped without a write");

  // Main scenarios reached
  c_ovf_irq: cover property ($rose(overflow_irq));
  c_cap_irq: cover property ($rose(channel_irq[1]));
  c_slverr: cover property (pready && pslverr);
  c_pin_drive: cover property ($rose(channel_pin_oe[0]));
endmodule

bind tcr_timer tcr_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq)
);

`default_nettype wire

// file: test/tcr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module tcr_cpu_model
  import tcr_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer, request held until pready is seen
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Answer taken at the rising edge that samples pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import tcr_pkg::*;
;
  // --------
  // Signals
  // --------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, overflow_irq, err, f;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [CH_N-1:0] pin_drv, pin_in, pin_out, pin_oe, channel_irq;
  logic [7:0] rd, base;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int t0, t1;

  typedef struct packed {
    logic w;
    logic [5:0] idx;
    logic [7:0] d;
    logic [7:0] exp;
    logic err;
  } tcr_row_t;

  // Reset values, decode and plain access
  localparam tcr_row_t ROWS [14] = '{
    '{1'h0, IDX_TSC, 8'h00, 8'h20, 1'h0}, '{1'h0, IDX_CNTH, 8'h00, 8'h00, 1'h0},
    '{1'h0, IDX_CNTL, 8'h00, 8'h00, 1'h0}, '{1'h0, IDX_MODH, 8'h00, 8'hFF, 1'h0},
    '{1'h0, IDX_MODL, 8'h00, 8'hFF, 1'h0}, '{1'h0, IDX_CSC0, 8'h00, 8'h00, 1'h0},
    '{1'h0, IDX_CSC1, 8'h00, 8'h00, 1'h0}, '{1'h0, 6'h2B, 8'h00, 8'h00, 1'h1},
    '{1'h1, IDX_CNTL, 8'h55, 8'h00, 1'h0}, '{1'h0, IDX_CNTL, 8'h00, 8'h00, 1'h0},
    '{1'h1, IDX_MODH, 8'h00, 8'h00, 1'h0}, '{1'h1, IDX_MODL, 8'h05, 8'h00, 1'h0},
    '{1'h0, IDX_MODL, 8'h00, 8'h05, 1'h0}, '{1'h0, 6'h1F, 8'h00, 8'h00, 1'h1}
  };

  // Pin level seen by both parties
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);

  tcr_timer dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq)
  );

  tcr_cpu_model cpu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  // Clock and cycle count
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // --------
  // Helpers
  // --------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    cpu.xfer(1'h1, i, d, rd, err);
  endtask

  task automatic rc(input logic [5:0] i, input logic [7:0] e, input string what);
    cpu.xfer(1'h0, i, 8'h00, rd, err);
    check(16'(rd), 16'(e), what);
  endtask

  // High cycles of channel 0 pin over two periods
  task automatic duty(input int exp, input string what);
    int hi;
    hi = 0;
    repeat (20) @(negedge pclk);
    repeat (12) begin
      @(negedge pclk);
      hi += int'(pin_out[0] === 1'h1);
    end
    check(16'(hi), 16'(exp), what);
  endtask

  // Cycle at the next channel 0 pin change
  task automatic edge_at(output int t);
    logic p;
    int n;
    p = pin_out[0];
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pin_out[0] === p && n < 1000);
    t = cyc;
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("wrong value at %0t: run timed out", $time);
    close_out();
  end

  // ------
  // Tests
  // ------
  initial begin
    presetn = 1'h0;
    pin_drv = 2'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ROWS[i]) begin
      cpu.xfer(ROWS[i].w, ROWS[i].idx, ROWS[i].d, rd, err);
      check(16'(rd), 16'(ROWS[i].exp), "table data");
      check(16'(err), 16'(ROWS[i].err), "table error");
    end
    $display("table done");
    wr(IDX_CVH0, 8'h00);
    wr(IDX_CVL0, 8'h03);
    wr(IDX_CSC0, 8'h14);
    repeat (3) @(negedge pclk);
    check(16'(pin_oe), 16'h0001, "compare drives pin");
    for (int k = 0; k < 7; k++) begin
      wr(IDX_TSC, 8'h30 | 8'(k));
      wr(IDX_TSC, 8'(k));
      edge_at(t0);
      edge_at(t1);
      check(16'(t1 - t0), 16'(6 << k), "toggle period");
    end
    rc(IDX_CSC0, 8'h94, "compare flag");
    $display("prescale done");
    wr(IDX_TSC, 8'h40);
    repeat (20) @(negedge pclk);
    check(16'(overflow_irq), 16'h0001, "overflow irq");
    rc(IDX_TSC, 8'hC0, "flag set");
    repeat (20) @(negedge pclk);
    wr(IDX_TSC, 8'h40);
    rc(IDX_TSC, 8'hC0, "clear after new overflow");
    wr(IDX_TSC, 8'hF0);
    rc(IDX_TSC, 8'hE0, "halted, clear bit reads 0");
    wr(IDX_TSC, 8'h60);
    rc(IDX_TSC, 8'h60, "flag cleared");
    wr(IDX_TSC, 8'hE0);
    rc(IDX_TSC, 8'h60, "writing 1 to flag");
    check(16'(overflow_irq), 16'h0000, "overflow irq off");
    rc(IDX_CNTH, 8'h00, "stopped high");
    rc(IDX_CNTL, 8'h00, "stopped low");
    wr(IDX_TSC, 8'h50);
    wr(IDX_MODH, 8'h00);
    repeat (40) @(negedge pclk);
    rc(IDX_TSC, 8'h40, "overflow held off");
    wr(IDX_MODL, 8'h05);
    repeat (20) @(negedge pclk);
    rc(IDX_TSC, 8'hC0, "overflow resumed");
    $display("overflow done");
    wr(IDX_TSC, 8'h70);
    wr(IDX_CSC0, 8'h1B);
    wr(IDX_TSC, 8'h40);
    duty(12, "full duty");
    wr(IDX_CSC0, 8'h1A);
    duty(8, "pwm duty");
    wr(IDX_CVH0, 8'h00);
    wr(IDX_CVL0, 8'h05);
    duty(6, "overflow beats compare");
    wr(IDX_CSC0, 8'h18);
    duty(0, "zero duty");
    $display("pwm done");
    for (int e = 1; e < 4; e++) begin
      base = 8'h40 | 8'(e << 2);
      wr(IDX_TSC, 8'h70);
      wr(IDX_CSC1, base);
      wr(IDX_TSC, 8'h40);
      for (int s = 0; s < 2; s++) begin
        f = (s == 0) ? e[0] : e[1];
        @(posedge pclk);
        pin_drv[1] <= (s == 0);
        repeat (10) @(negedge pclk);
        rc(IDX_CSC1, {f, base[6:0]}, "capture flag");
        check(16'(channel_irq[1]), 16'(f), "channel irq");
        wr(IDX_CSC1, base);
      end
      rc(IDX_CVH1, 8'h00, "capture high");
      cpu.xfer(1'h0, IDX_CVL1, 8'h00, rd, err);
      check(16'(rd < 8'h06), 16'h0001, "capture low");
    end
    $display("capture done");
    wr(IDX_TSC, 8'h70);
    wr(IDX_CSC0, 8'h24);
    wr(IDX_CSC1, 8'h14);
    repeat (3) @(negedge pclk);
    check(16'(pin_oe), 16'h0001, "channel 1 released");
    $display("buffered done");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rc(IDX_TSC, 8'h20, "control after reset");
    rc(IDX_CSC0, 8'h00, "channel after reset");
    check(16'(pin_oe), 16'h0000, "pins released");
    $display("reset done");
    close_out();
  end
endmodule

`default_nettype wire
